// *** hdl/sra_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sra_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_in_ready,
   // Drain side
   output      logic             o_out_valid,
   output      logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("sra_fifo: DEPTH must be a power of two >= 2");
      end
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
      logic                        ready;
   } sra_fifo_s;

   sra_fifo_s st_reg;
   sra_fifo_s st_next;
   logic      push;
   logic      pop;

   always_comb begin
      st_next = st_reg;
      push    = i_in_valid && st_reg.ready;
      pop     = i_out_ready && (st_reg.count != '0);
      if (push) begin
         st_next.mem[st_reg.wr_ptr] = i_in_data;
         st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_next.count = st_reg.count + 1'b1;
      end else if (pop && !push) begin
         st_next.count = st_reg.count - 1'b1;
      end
      // Registered ready keeps the top-level output straight from a flop
      st_next.ready = (st_next.count != (AW + 1)'(DEPTH));
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_reg       <= '0;
         st_reg.ready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_in_ready  = st_reg.ready;
   assign o_out_valid = (st_reg.count != '0);
   assign o_out_data  = st_reg.mem[st_reg.rd_ptr];
endmodule

// *** hdl/sra_top.sv ***
// Serial register access logic of a dual-channel sampling converter
`timescale 1ns/1ps
module sra_top #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_NRST,
   // Serial pins
   input  wire logic        I_SCLK,
   input  wire logic        I_NCS,
   input  wire logic        I_CONFIG_SERIAL_IN,
   input  wire logic [3:0]  I_PGA_GAIN_SELECT,
   // Conversion results from the converter core
   input  wire logic        I_RESULT_VALID,
   input  wire logic [23:0] I_RESULT_PAIR,
   output      logic        O_RESULT_READY,
   // Serial outputs
   output      logic        O_RESULT_LINE_A,
   output      logic        O_RESULT_LINE_A_OE,
   output      logic        O_RESULT_LINE_B,
   output      logic        O_RESULT_LINE_B_OE,
   // Applied configuration
   output      logic [3:0]  O_PGA_GAIN,
   output      logic [2:0]  O_POWER_DOWN_SELECT,
   output      logic        O_CAL_ACTIVE,
   output      logic        O_REG_MODE
);
   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("sra_top: FIFO_DEPTH must be at least 2");
      end
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic                sclk_s1;
      logic                sclk_s2;
      logic                sclk_d;
      logic                cs_s1;
      logic                cs_s2;
      logic                cs_d;
      logic                din_s1;
      logic                din_s2;
      logic [3:0]          gpin_s1;
      logic [3:0]          gpin_s2;
      sra_pkg::sra_state_e state;
      logic [5:0]          edge_cnt;
      logic [15:0]         shift_in;
      sra_pkg::sra_ctl_s   control;
      logic [11:0]         off_a;
      logic [11:0]         off_b;
      logic [6:0]          gain_a;
      logic [6:0]          gain_b;
      sra_pkg::sra_ctl_s   applied;
      logic                cal_frame;
      logic                reg_mode;
      sra_pkg::sra_pair_s  raw;
      logic [23:0]         sh_a;
      logic [23:0]         sh_b;
      logic                line_a;
      logic                line_b;
      logic                oe;
   } sra_st_s;

   localparam sra_st_s ST_RESET = '{sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_d: 1'b1,
                                    cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
                                    state: sra_pkg::ST_IDLE, default: '0};

   sra_st_s            st_reg;
   sra_st_s            st_next;
   sra_pkg::sra_pair_s fifo_data;
   logic               fifo_valid;
   logic               fifo_ready;
   logic               fifo_pop;
   logic               fall;
   logic               frame_start;
   logic               reg_mode_now;
   logic               do_commit;
   logic [3:0]         tgt_code;
   logic [11:0]        sel_word;
   logic [11:0]        res_a_corr;
   logic [11:0]        res_b_corr;

   // ==========================================================
   // Conversion result buffer
   sra_fifo #(
      .WIDTH (24),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (I_CLK),
      .i_nrst      (I_NRST),
      .i_in_valid  (I_RESULT_VALID),
      .i_in_data   (I_RESULT_PAIR),
      .o_in_ready  (fifo_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (fifo_pop)
   );

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      // Two flops on every pin; clock and select get a third flop, and both their last two stages feed edge detection
      st_next.sclk_s1 = I_SCLK;
      st_next.sclk_s2 = st_reg.sclk_s1;
      st_next.sclk_d  = st_reg.sclk_s2;
      st_next.cs_s1   = I_NCS;
      st_next.cs_s2   = st_reg.cs_s1;
      st_next.cs_d    = st_reg.cs_s2;
      st_next.din_s1  = I_CONFIG_SERIAL_IN;
      st_next.din_s2  = st_reg.din_s1;
      st_next.gpin_s1 = I_PGA_GAIN_SELECT;
      st_next.gpin_s2 = st_reg.gpin_s1;

      fall         = st_reg.sclk_d && !st_reg.sclk_s2;
      frame_start  = (st_reg.state == sra_pkg::ST_IDLE) && !st_reg.cs_s2 && st_reg.cs_d;
      reg_mode_now = (st_reg.gpin_s2 == sra_pkg::PIN_REGMODE);
      tgt_code     = st_reg.shift_in[15:12];
      fifo_pop     = 1'b0;
      do_commit    = 1'b0;

      // Offset removed except in a calibration frame, whose result is corrupt anyway
      res_a_corr = st_reg.cal_frame ? st_reg.raw.res_a : st_reg.raw.res_a - st_reg.off_a;
      res_b_corr = st_reg.cal_frame ? st_reg.raw.res_b : st_reg.raw.res_b - st_reg.off_b;

      // Readback decode; unknown codes fall back to the result
      unique case (st_reg.control.readback_select)
         sra_pkg::CODE_CONTROL: sel_word = st_reg.control;
         sra_pkg::CODE_OFF_A:   sel_word = st_reg.off_a;
         sra_pkg::CODE_OFF_B:   sel_word = st_reg.off_b;
         sra_pkg::CODE_GAIN_A:  sel_word = {5'h00, st_reg.gain_a};
         sra_pkg::CODE_GAIN_B:  sel_word = {5'h00, st_reg.gain_b};
         default:               sel_word = res_a_corr;
      endcase

      unique case (st_reg.state)
         sra_pkg::ST_IDLE: begin
            if (frame_start) begin
               // Frame start fixes the configuration for this conversion
               st_next.state    = sra_pkg::ST_FRAME;
               st_next.edge_cnt = '0;
               st_next.reg_mode = reg_mode_now;
               st_next.applied  = st_reg.control;
               if (!reg_mode_now) begin
                  st_next.applied.pga_gain_select = st_reg.gpin_s2;
               end
               st_next.cal_frame = reg_mode_now && st_reg.control.cal_start;
               fifo_pop          = fifo_valid;
               st_next.raw       = fifo_valid ? fifo_data : '0;
               if (reg_mode_now && st_reg.control.cal_start && fifo_valid) begin
                  // Inputs are shorted during calibration: the result is the offset
                  st_next.off_a = fifo_data.res_a;
                  st_next.off_b = fifo_data.res_b;
               end
            end
         end
         sra_pkg::ST_FRAME: begin
            if (st_reg.cs_s2) begin
               // Early rise: nothing committed if before edge 17, partial frame dropped
               st_next.state = sra_pkg::ST_IDLE;
               st_next.oe    = 1'b0;
            end else if (fall) begin
               st_next.edge_cnt = st_reg.edge_cnt + 6'h01;
               if (st_reg.edge_cnt < sra_pkg::EDGE_LAST_DATA) begin
                  st_next.shift_in = {st_reg.shift_in[14:0], st_reg.din_s2};
               end
               if (st_next.edge_cnt == sra_pkg::EDGE_COMMIT && st_reg.reg_mode && reg_mode_now) begin
                  do_commit = 1'b1;
                  unique case (tgt_code)
                     sra_pkg::CODE_CONTROL: st_next.control = st_reg.shift_in[11:0];
                     sra_pkg::CODE_OFF_A:   st_next.off_a   = st_reg.shift_in[11:0];
                     sra_pkg::CODE_OFF_B:   st_next.off_b   = st_reg.shift_in[11:0];
                     sra_pkg::CODE_GAIN_A:  st_next.gain_a  = st_reg.shift_in[11:5];
                     sra_pkg::CODE_GAIN_B:  st_next.gain_b  = st_reg.shift_in[11:5];
                     default:               do_commit       = 1'b0;
                  endcase
               end
               if (st_next.edge_cnt == sra_pkg::EDGE_READ) begin
                  // Line A: selected word, then B; line B: B, then A
                  st_next.sh_a   = {sel_word, res_b_corr};
                  st_next.sh_b   = {res_b_corr, res_a_corr};
                  st_next.line_a = sel_word[11];
                  st_next.line_b = res_b_corr[11];
                  st_next.oe     = 1'b1;
               end else if (st_reg.oe) begin
                  st_next.sh_a   = {st_reg.sh_a[22:0], 1'b0};
                  st_next.sh_b   = {st_reg.sh_b[22:0], 1'b0};
                  st_next.line_a = st_reg.sh_a[22];
                  st_next.line_b = st_reg.sh_b[22];
               end
               if (st_next.edge_cnt == sra_pkg::EDGE_END_OUT) begin
                  st_next.oe    = 1'b0;
                  st_next.state = sra_pkg::ST_HOLD;
               end
            end
         end
         sra_pkg::ST_HOLD: begin
            if (st_reg.cs_s2) begin
               st_next.state = sra_pkg::ST_IDLE;
            end
         end
         default: begin
            st_next.state = sra_pkg::ST_IDLE;
         end
      endcase
      if (!st_next.oe) begin
         st_next.line_a = 1'b0;
         st_next.line_b = 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign O_RESULT_READY      = fifo_ready;
   assign O_RESULT_LINE_A     = st_reg.line_a;
   assign O_RESULT_LINE_A_OE  = st_reg.oe;
   assign O_RESULT_LINE_B     = st_reg.line_b;
   assign O_RESULT_LINE_B_OE  = st_reg.oe;
   assign O_PGA_GAIN          = st_reg.applied.pga_gain_select;
   assign O_POWER_DOWN_SELECT = st_reg.applied.power_down_select;
   assign O_CAL_ACTIVE        = st_reg.cal_frame;
   assign O_REG_MODE          = st_reg.reg_mode;

   // ==========================================================
   // Assertions
   logic data_edge;
   logic commit_edge;
   logic read_edge;
   assign data_edge   = (st_reg.state == sra_pkg::ST_FRAME) && !st_reg.cs_s2 && fall
                        && (st_reg.edge_cnt < sra_pkg::EDGE_LAST_DATA);
   assign commit_edge = (st_reg.state == sra_pkg::ST_FRAME) && !st_reg.cs_s2 && fall
                        && (st_reg.edge_cnt == sra_pkg::EDGE_LAST_DATA);
   assign read_edge   = (st_reg.state == sra_pkg::ST_FRAME) && !st_reg.cs_s2 && fall
                        && (st_reg.edge_cnt == sra_pkg::EDGE_READ - 6'h01);

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   serial_sample_a: assert property (data_edge |=> st_reg.shift_in[0] == $past(st_reg.din_s2))
      else $error("data-in bit not sampled on falling edge");
   ctl_commit_a: assert property (commit_edge && st_reg.reg_mode && reg_mode_now
                                  && tgt_code == sra_pkg::CODE_CONTROL
                                  |=> st_reg.control == $past(st_reg.shift_in[11:0]))
      else $error("control not loaded with twelve data bits on commit");
   no_commit_a: assert property (!commit_edge |=> $stable(st_reg.control) && $stable(st_reg.gain_a))
      else $error("register changed outside the commit edge");
   pin_mode_a: assert property (commit_edge && !reg_mode_now |=> $stable(st_reg.control))
      else $error("serial write taken in pin-driven mode");
   gain_seven_a: assert property (commit_edge && st_reg.reg_mode && reg_mode_now
                                  && tgt_code == sra_pkg::CODE_GAIN_A
                                  |=> st_reg.gain_a == $past(st_reg.shift_in[11:5]))
      else $error("gain register did not take seven bits after address");
   readout_start_a: assert property (read_edge |=> st_reg.oe && st_reg.line_a == $past(sel_word[11])
                                     && st_reg.line_b == $past(res_b_corr[11]))
      else $error("readback not started on nineteenth edge");
   oe_rise_a: assert property ($rose(st_reg.oe) |-> st_reg.edge_cnt == sra_pkg::EDGE_READ)
      else $error("output lines enabled at wrong edge");
   apply_next_a: assert property (frame_start && reg_mode_now |=> st_reg.applied == $past(st_reg.control))
      else $error("configuration not applied at frame start");
   cal_store_a: assert property (frame_start && reg_mode_now && st_reg.control.cal_start && fifo_valid
                                 |=> st_reg.off_a == $past(fifo_data.res_a) && st_reg.cal_frame)
      else $error("calibration did not store offset");
   sel_decode_a: assert property (read_edge && st_reg.control.readback_select == sra_pkg::CODE_OFF_B
                                  |=> st_reg.sh_a[23:12] == $past(st_reg.off_b))
      else $error("readback select decode wrong");

   cover_write_c: cover property (do_commit && tgt_code == sra_pkg::CODE_CONTROL ##1 st_reg.reg_mode);
   cover_read_c:  cover property (read_edge && st_reg.control.readback_select == sra_pkg::CODE_GAIN_A);
   cover_cal_c:   cover property (frame_start && st_reg.control.cal_start && fifo_valid);
endmodule

// *** shared/sra_pkg.sv ***
// Constants and types of the serial register access block
package sra_pkg;

   // ==========================================================
   // Frame edge numbers (falling serial-clock edges after select)
   localparam logic [5:0] EDGE_LAST_DATA = 6'h10;  // 16th edge
   localparam logic [5:0] EDGE_COMMIT    = 6'h11;  // 17th edge
   localparam logic [5:0] EDGE_READ      = 6'h13;  // 19th edge
   localparam logic [5:0] EDGE_END_OUT   = 6'h2D;  // 45th edge

   // ==========================================================
   // Widths
   localparam int REG_W   = 12;
   localparam int GAIN_W  = 7;
   localparam int CODE_W  = 4;
   localparam int FRAME_W = 16;

   // ==========================================================
   // Target and read-select codes
   localparam logic [3:0] CODE_RESULT  = 4'h0;
   localparam logic [3:0] CODE_CONTROL = 4'h1;
   localparam logic [3:0] CODE_OFF_A   = 4'h2;
   localparam logic [3:0] CODE_OFF_B   = 4'h3;
   localparam logic [3:0] CODE_GAIN_A  = 4'h4;
   localparam logic [3:0] CODE_GAIN_B  = 4'h5;

   // ==========================================================
   // Control register layout, MSB first in the frame
   typedef struct packed {
      logic [3:0] readback_select;    // bits 11..8
      logic       cal_start;          // bit 7
      logic [2:0] power_down_select;  // bits 6..4
      logic [3:0] pga_gain_select;    // bits 3..0
   } sra_ctl_s;

   localparam logic [11:0] CTL_RESET   = 12'h000;
   localparam logic [11:0] OFF_RESET   = 12'h000;
   localparam logic [6:0]  GAIN_RESET  = 7'h00;
   localparam logic [3:0]  PIN_REGMODE = 4'h0;

   // ==========================================================
   // One conversion: channel A and channel B results
   typedef struct packed {
      logic [11:0] res_a;
      logic [11:0] res_b;
   } sra_pair_s;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FRAME = 2'b01,
      ST_HOLD  = 2'b10
   } sra_state_e;

endpackage

// *** sim/sra_host_model.sv ***
// Behavioural host controller on the far side of the serial register link
`timescale 1ns/1ps
module sra_host_model (
   // Link to the device
   output      logic sclk,
   output      logic ncs,
   output      logic din,
   // Device outputs
   input  wire logic line_a,
   input  wire logic line_b,
   input  wire logic line_oe
);
   // Clock idles high, select idles high, outside any frame
   initial begin
      sclk = 1'b1;
      ncs  = 1'b1;
      din  = 1'b0;
   end

   // ==========================================================
   // One frame of n falls at 400 ns; lines taken at falls 20..43
   task automatic frame(input logic [15:0] word, input int n, output logic [23:0] got_a,
                        output logic [23:0] got_b, output logic oe_pre, output logic oe_mid);
      got_a  = 24'h000000;
      got_b  = 24'h000000;
      oe_pre = 1'b0;
      oe_mid = 1'b1;
      // Odd offset keeps the link clock out of phase with the system clock
      #13;
      ncs = 1'b0;
      #300;
      for (int k = 1; k <= n; k++) begin
         din = (k <= 16) ? word[16-k] : 1'b0;
         #100;
         sclk = 1'b0;
         if (k == 19) begin
            oe_pre = line_oe;
         end
         if (k >= 20 && k <= 43) begin
            got_a[43-k] = line_a;
            got_b[43-k] = line_b;
            oe_mid      = oe_mid & line_oe;
         end
         #200;
         sclk = 1'b1;
         #100;
      end
      ncs = 1'b1;
      #400;
   endtask
endmodule

// *** sim/sra_top_tb.sv ***
// Self-checking testbench of the serial register access block
`timescale 1ns/1ps
module sra_top_tb;
   logic                clk;
   logic                nrst;
   logic [3:0]          pins;
   logic                res_valid;
   logic [23:0]         res_pair;
   logic                sclk;
   logic                ncs;
   logic                din;
   logic                res_ready;
   logic                line_a;
   logic                line_a_oe;
   logic                line_b;
   logic                line_b_oe;
   logic [3:0]          pga_gain;
   logic [2:0]          pd_sel;
   logic                cal_active;
   logic                reg_mode;
   int                  num_errors = 0;
   int                  n_compared = 0;
   logic [31:0]         seed = 32'hB321;
   logic [11:0]         ctl;
   logic [11:0]         off_a;
   logic [11:0]         off_b;
   logic [6:0]          g_a;
   logic [6:0]          g_b;
   sra_pkg::sra_pair_s  q[$];

   sra_top #(.FIFO_DEPTH(16)) dut_u (
      .I_CLK(clk), .I_NRST(nrst), .I_SCLK(sclk), .I_NCS(ncs), .I_CONFIG_SERIAL_IN(din),
      .I_PGA_GAIN_SELECT(pins), .I_RESULT_VALID(res_valid), .I_RESULT_PAIR(res_pair),
      .O_RESULT_READY(res_ready), .O_RESULT_LINE_A(line_a), .O_RESULT_LINE_A_OE(line_a_oe),
      .O_RESULT_LINE_B(line_b), .O_RESULT_LINE_B_OE(line_b_oe), .O_PGA_GAIN(pga_gain),
      .O_POWER_DOWN_SELECT(pd_sel), .O_CAL_ACTIVE(cal_active), .O_REG_MODE(reg_mode));

   sra_host_model host_u (.sclk(sclk), .ncs(ncs), .din(din), .line_a(line_a), .line_b(line_b),
                          .line_oe(line_a_oe));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // ==========================================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Valid stays up between pushes; the caller drops it afterwards
   task automatic push(input sra_pkg::sra_pair_s p);
      int t;
      res_valid = 1'b1;
      res_pair  = p;
      for (t = 0; t < 100 && res_ready !== 1'b1; t++) tick(1);
      if (t == 100) begin
         num_errors++;
         wrap_up();
      end else begin
         tick(1);
         q.push_back(p);
      end
   endtask

   // ==========================================================
   // One frame, with the expected register and line behaviour
   task automatic run_frame(input logic [15:0] w, input int n);
      sra_pkg::sra_pair_s pr;
      logic [23:0]        ga;
      logic [23:0]        gb;
      logic [11:0]        ra;
      logic [11:0]        rb;
      logic [11:0]        sw;
      logic               cal;
      logic               rm;
      logic               hv;
      logic               pre;
      logic               mid;
      logic [3:0]         eg;
      logic [2:0]         ep;
      hv  = (q.size() > 0);
      pr  = hv ? q.pop_front() : 24'h000000;
      rm  = (pins == sra_pkg::PIN_REGMODE);
      cal = rm & ctl[7];
      // An empty buffer gives no measurement, so the offsets keep their value
      if (cal && hv) begin
         off_a = pr.res_a;
         off_b = pr.res_b;
      end
      eg = rm ? ctl[3:0] : pins;
      ep = ctl[6:4];
      host_u.frame(w, n, ga, gb, pre, mid);
      if (n >= 17 && rm) begin
         case (w[15:12])
            sra_pkg::CODE_CONTROL: ctl = w[11:0];
            sra_pkg::CODE_OFF_A: off_a = w[11:0];
            sra_pkg::CODE_OFF_B: off_b = w[11:0];
            sra_pkg::CODE_GAIN_A: g_a = w[11:5];
            sra_pkg::CODE_GAIN_B: g_b = w[11:5];
            default: ;
         endcase
      end
      // Offsets committed at edge 17 already correct the result shifted from edge 19
      ra = cal ? pr.res_a : pr.res_a - off_a;
      rb = cal ? pr.res_b : pr.res_b - off_b;
      case (ctl[11:8])
         sra_pkg::CODE_CONTROL: sw = ctl;
         sra_pkg::CODE_OFF_A: sw = off_a;
         sra_pkg::CODE_OFF_B: sw = off_b;
         sra_pkg::CODE_GAIN_A: sw = {5'h00, g_a};
         sra_pkg::CODE_GAIN_B: sw = {5'h00, g_b};
         default: sw = ra;
      endcase
      if (n >= 45) begin
         check("line a", {8'h00, ga}, {8'h00, sw, rb});
         check("line b", {8'h00, gb}, {8'h00, rb, ra});
         check("enable before edge 19", {31'h0, pre}, 32'h0);
         check("enable during output", {31'h0, mid}, 32'h1);
      end
      tick(6);
      check("applied gain", {28'h0, pga_gain}, {28'h0, eg});
      check("register mode", {31'h0, reg_mode}, {31'h0, rm});
      check("calibration frame", {31'h0, cal_active}, {31'h0, cal});
      check("enable idle", {31'h0, line_b_oe}, 32'h0);
      if (rm) begin
         check("power down", {29'h0, pd_sel}, {29'h0, ep});
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      nrst      = 1'b0;
      pins      = 4'h0;
      res_valid = 1'b0;
      res_pair  = 24'h000000;
      ctl       = 12'h000;
      off_a     = 12'h000;
      off_b     = 12'h000;
      g_a       = 7'h00;
      g_b       = 7'h00;
      tick(5);
      nrst = 1'b1;
      tick(4);
      check("ready after reset", {31'h0, res_ready}, 32'h1);
      check("gain after reset", {28'h0, pga_gain}, 32'h0);
      for (int i = 0; i < 16; i++) push(24'(rnd()));
      res_valid = 1'b0;
      tick(2);
      check("ready when full", {31'h0, res_ready}, 32'h0);
      // Reset values of the offset and gain registers read back one by one, control read back as written
      for (int c = 1; c <= 5; c++) run_frame({4'h1, 4'(c), 8'h00}, 45);
      // Random writes, readback, then results restored
      for (int i = 0; i < 3; i++) begin
         for (int c = 2; c <= 5; c++) begin
            run_frame({4'(c), 12'(rnd())}, 45);
            run_frame({4'h1, 4'(c), 8'(rnd()) & 8'h7F}, 45);
            run_frame({4'h1, 4'h0, 8'(rnd()) & 8'h7F}, 45);
            if (q.size() < 14) begin
               push(24'(rnd()));
               res_valid = 1'b0;
            end
         end
      end
      // Refused target codes and an aborted frame
      run_frame({4'h0, 12'(rnd())}, 45);
      run_frame({4'h7, 12'(rnd())}, 45);
      run_frame({4'hF, 12'(rnd())}, 45);
      run_frame({4'h2, 12'(rnd())}, 16);
      run_frame({4'h1, 12'h200}, 45);
      // Calibration, then both stored offsets read back
      push(24'(rnd()));
      push(24'(rnd()));
      push(24'(rnd()));
      res_valid = 1'b0;
      run_frame(16'h1085, 45);
      run_frame(16'h1005, 45);
      run_frame(16'h1205, 45);
      run_frame(16'h1305, 45);
      run_frame(16'h1000, 45);
      // Pin-driven mode ignores serial writes
      pins = 4'h9;
      tick(4);
      run_frame(16'h100F, 45);
      pins = 4'h0;
      tick(4);
      run_frame(16'h1100, 45);
      run_frame(16'h1053, 45);
      run_frame(16'h1000, 45);
      wrap_up();
   end
endmodule
